// File: ftsp_pkg.sv
// Constants and types shared by the flow-through synchronous RAM port.
// Assumes a single core clock; the controller drives the bus on the same clock.
package ftsp_pkg;

    // Word organisation: four byte lanes of nine bits
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;

    // Address width of the modelled array
    localparam int ADDR_W = 10;
    localparam int WORDS = 1 << ADDR_W;

    // Burst counter
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_STEP_ONE = 2'h1;
    localparam logic [BURST_W-1:0] BURST_STEP_RST = 2'h0;

    // Write buffer between bus and array
    localparam int WBUF_DEPTH = 8;
    localparam int WBUF_W = ADDR_W + LANES + DATA_W;

    // Bus cycle kinds remembered for burst continue
    typedef enum logic [1:0] {
        CYC_DESEL,
        CYC_READ,
        CYC_WRITE
    } ftsp_cyc_t;

    // State of the port apart from the write buffer and the array
    typedef struct packed {
        logic sleep_meta;
        logic sleep_now;
        ftsp_cyc_t cyc;
        logic [ADDR_W-1:0] base_addr;
        logic [BURST_W-1:0] step_cnt;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [LANES-1:0] wr_lanes_n;
    } ftsp_state_t;

    localparam ftsp_state_t ST_RESET = '{
        sleep_meta: 1'b0,
        sleep_now: 1'b0,
        cyc: CYC_DESEL,
        base_addr: '0,
        step_cnt: BURST_STEP_RST,
        wr_pend: 1'b0,
        wr_addr: '0,
        wr_lanes_n: '1
    };

endpackage

// File: ftsp_fifo.sv
// Show-ahead FIFO holding late-write words on their way to the array.
// Assumes both sides sit on core_clk_i; valid/ready on each side.
`timescale 1ns/1ps
`default_nettype none
module ftsp_fifo
    import ftsp_pkg::*;
#(
    parameter int WIDTH = WBUF_W,
    parameter int DEPTH = WBUF_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W:0] count;
    } ftsp_fifo_state_t;

    ftsp_fifo_state_t st;
    ftsp_fifo_state_t next_st;
    logic [WIDTH-1:0] store [DEPTH];
    logic push;
    logic pop;

    assign in_ready_o = (st.count != DEPTH[PTR_W:0]);
    assign out_valid_o = (st.count != '0);
    assign out_data_o = store[st.rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = (st.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            store[st.wr_ptr] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// File: ftsp_core.sv
// Flow-through, no-turnaround synchronous static RAM port with its array.
// Assumes the controller drives address, controls and write data on core_clk_i;
// output enable and sleep request arrive asynchronously.
//
// Operation
// - Address, data and controls are taken on each rising edge; writes start there.
// - Clock hold high makes the edge ignored; cycle state held, but sleep flops and write buffer still advance.
// - Clock hold keeps a read driving and leaves a write's bus undriven.
// - Read data drives in the cycle the address was registered.
// - Write address on one edge, write data taken on the next edge.
// - A write may follow a read directly, no idle cycle.
// - Load read: selects active, store select high; drives only with output enable low.
// - Load write writes only lanes whose strobes are low.
// - Store select low with no strobe low is a no-operation, bus undriven.
// - Step high repeats previous cycle type at next counter address.
// - Two-bit step counter clears to zero on each load, advances on each continue.
// - Output drivers turn off during writes automatically.
// - Output enable high turns drivers off at once, unclocked.
// - Outputs stay undriven from power-up until normal cycles.
// - Nine-bit lanes, each written only under its own strobe.
// - Step high uses the counted address; step low loads the external one.
// - Four accesses per burst: linear modulo four or interleaved by XOR.
// - Sleep entered two cycles after request, left two cycles after release.
`timescale 1ns/1ps
`default_nettype none
module ftsp_core
    import ftsp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_hold_i,
    input wire logic burst_step_i,
    input wire logic store_sel_n_i,
    input wire logic [LANES-1:0] byte_lane_strobes_n_i,
    input wire logic chip_sel_first_n_i,
    input wire logic chip_sel_second_i,
    input wire logic chip_sel_third_n_i,
    input wire logic out_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic linear_order_n_i,
    input wire logic [ADDR_W-1:0] burst_addr_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic wr_buf_ready_o,
    output logic sleep_state_o
);

    // Bus command classified at an edge
    typedef enum {
        CMD_NONE,
        CMD_LOAD_READ,
        CMD_LOAD_WRITE,
        CMD_WRITE_ABORT,
        CMD_DESELECT,
        CMD_CONT_READ,
        CMD_CONT_WRITE,
        CMD_CONT_ABORT,
        CMD_CONT_DESEL
    } ftsp_cmd_t;

    ftsp_state_t st;
    ftsp_state_t next_st;
    ftsp_cmd_t cmd;

    logic edge_live;
    logic selected;
    logic any_lane;
    logic push;
    logic [WBUF_W-1:0] push_word;
    logic head_valid;
    logic head_ready;
    logic [WBUF_W-1:0] head_word;
    logic [ADDR_W-1:0] head_addr;
    logic [LANES-1:0] head_lanes_n;
    logic [DATA_W-1:0] head_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] cont_addr;
    logic [BURST_W-1:0] cont_step;
    logic head_hit;
    logic drive;

    // Address for a given burst step, linear or interleaved order
    function automatic logic [ADDR_W-1:0] burst_addr_at(
        input logic [ADDR_W-1:0] base,
        input logic [BURST_W-1:0] step,
        input logic interleave
    );
        logic [BURST_W-1:0] low;
        low = interleave ? (base[BURST_W-1:0] ^ step) : (base[BURST_W-1:0] + step);
        return {base[ADDR_W-1:BURST_W], low};
    endfunction

    // Chip select decode
    assign selected = ~chip_sel_first_n_i & chip_sel_second_i & ~chip_sel_third_n_i;
    assign any_lane = ~&byte_lane_strobes_n_i;

    assign cont_step = st.step_cnt + BURST_STEP_ONE;
    assign cont_addr = burst_addr_at(st.base_addr, cont_step, linear_order_n_i);
    assign rd_addr = burst_addr_at(st.base_addr, st.step_cnt, linear_order_n_i);

    // Edge is live unless held or asleep
    assign edge_live = ~st.sleep_now & ~clk_hold_i;

    // Classify the command presented at this edge
    always_comb begin
        cmd = CMD_NONE;
        if (edge_live) begin
            if (burst_step_i) begin
                case (st.cyc)
                    CYC_READ: begin
                        cmd = CMD_CONT_READ;
                    end
                    CYC_WRITE: begin
                        cmd = any_lane ? CMD_CONT_WRITE : CMD_CONT_ABORT;
                    end
                    default: begin
                        cmd = CMD_CONT_DESEL;
                    end
                endcase
            end else if (!selected) begin
                cmd = CMD_DESELECT;
            end else if (store_sel_n_i) begin
                cmd = CMD_LOAD_READ;
            end else if (any_lane) begin
                cmd = CMD_LOAD_WRITE;
            end else begin
                cmd = CMD_WRITE_ABORT;
            end
        end
    end

    // Next-state decode of the bus cycle
    always_comb begin
        next_st = st;
        push = 1'b0;
        // Sleep request passes two flops before use
        next_st.sleep_meta = sleep_request_i;
        next_st.sleep_now = st.sleep_meta;
        // Data of the write registered on the previous live edge
        if (edge_live && st.wr_pend) begin
            push = 1'b1;
            next_st.wr_pend = 1'b0;
        end
        case (cmd)
            CMD_LOAD_READ: begin
                next_st.base_addr = burst_addr_i;
                next_st.step_cnt = BURST_STEP_RST;
                next_st.cyc = CYC_READ;
            end
            CMD_LOAD_WRITE: begin
                next_st.base_addr = burst_addr_i;
                next_st.step_cnt = BURST_STEP_RST;
                next_st.cyc = CYC_WRITE;
                next_st.wr_pend = 1'b1;
                next_st.wr_addr = burst_addr_i;
                next_st.wr_lanes_n = byte_lane_strobes_n_i;
            end
            CMD_WRITE_ABORT: begin
                next_st.base_addr = burst_addr_i;
                next_st.step_cnt = BURST_STEP_RST;
                next_st.cyc = CYC_WRITE;
            end
            CMD_DESELECT: begin
                next_st.base_addr = burst_addr_i;
                next_st.step_cnt = BURST_STEP_RST;
                next_st.cyc = CYC_DESEL;
            end
            CMD_CONT_WRITE: begin
                next_st.step_cnt = cont_step;
                next_st.wr_pend = 1'b1;
                next_st.wr_addr = cont_addr;
                next_st.wr_lanes_n = byte_lane_strobes_n_i;
            end
            CMD_CONT_READ, CMD_CONT_ABORT, CMD_CONT_DESEL: begin
                next_st.step_cnt = cont_step;
            end
            default: begin
                next_st.cyc = st.cyc;
            end
        endcase
    end

    // Single register for all port state outside the write buffer and the array
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Late-write buffer between bus and array
    assign push_word = {st.wr_addr, st.wr_lanes_n, dq_i};

    ftsp_fifo #(
        .WIDTH(WBUF_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(push),
        .in_ready_o(wr_buf_ready_o),
        .in_data_i(push_word),
        .out_valid_o(head_valid),
        .out_ready_i(head_ready),
        .out_data_o(head_word)
    );

    assign head_addr = head_word[WBUF_W-1 -: ADDR_W];
    assign head_lanes_n = head_word[DATA_W +: LANES];
    assign head_data = head_word[DATA_W-1:0];

    // Array state is preserved while asleep
    assign head_ready = ~st.sleep_now;
    assign head_hit = head_valid & (head_addr == rd_addr);

    // Per-lane array, write and read with bypass of the pending word
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] lane_mem [WORDS];
            logic lane_we;
            logic lane_byp;

            assign lane_we = head_valid & head_ready & ~head_lanes_n[g];
            assign lane_byp = head_hit & ~head_lanes_n[g];

            always_ff @(posedge core_clk_i) begin
                if (lane_we) begin
                    lane_mem[head_addr] <= head_data[g*LANE_W +: LANE_W];
                end
            end

            // Pending lane wins over the stale array word
            assign dq_o[g*LANE_W +: LANE_W] = lane_byp ? head_data[g*LANE_W +: LANE_W] : lane_mem[rd_addr];
        end
    endgenerate

    // Output drivers: read cycles only, gated at once by output enable
    assign drive = (st.cyc == CYC_READ) & ~st.sleep_now;
    assign dq_oe_n_o = ~(drive & ~out_enable_n_i);

    assign sleep_state_o = st.sleep_now;

endmodule
`default_nettype wire

// File: ftsp_core_props.sv
// Concurrent checks on the RAM port's bus pins.
// Assumes it is bound to ftsp_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ftsp_core_props
    import ftsp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_hold_i,
    input wire logic burst_step_i,
    input wire logic store_sel_n_i,
    input wire logic [LANES-1:0] byte_lane_strobes_n_i,
    input wire logic chip_sel_first_n_i,
    input wire logic chip_sel_second_i,
    input wire logic chip_sel_third_n_i,
    input wire logic out_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic dq_oe_n_o,
    input wire logic sleep_state_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic sel;
    logic go;
    assign sel = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
    assign go = !clk_hold_i && !sleep_state_o && !burst_step_i;
    property p_rd;
        go && sel && store_sel_n_i ##1 !out_enable_n_i && !sleep_state_o |-> !dq_oe_n_o;
    endproperty
    a_rd: assert property (p_rd) else $error("load read not driving");
    property p_wr;
        go && sel && !store_sel_n_i |=> dq_oe_n_o;
    endproperty
    a_wr: assert property (p_wr) else $error("bus driven in write cycle");
    property p_desel;
        go && !sel |=> dq_oe_n_o;
    endproperty
    a_desel: assert property (p_desel) else $error("bus driven after deselect");
    property p_dcont;
        go && !sel ##1 !clk_hold_i && !sleep_state_o && burst_step_i |=> dq_oe_n_o;
    endproperty
    a_dcont: assert property (p_dcont) else $error("deselect continue drove bus");
    property p_oe;
        out_enable_n_i |-> dq_oe_n_o;
    endproperty
    a_oe: assert property (p_oe) else $error("output enable high but driving");
    property p_slp;
        sleep_state_o |-> dq_oe_n_o;
    endproperty
    a_slp: assert property (p_slp) else $error("driving while asleep");
    property p_sin;
        sleep_request_i [*3] |-> sleep_state_o;
    endproperty
    a_sin: assert property (p_sin) else $error("sleep not entered in two cycles");
    property p_sout;
        !sleep_request_i [*3] |-> !sleep_state_o;
    endproperty
    a_sout: assert property (p_sout) else $error("sleep not left in two cycles");
    property p_hold;
        clk_hold_i && !sleep_state_o ##1 $stable(out_enable_n_i) && !sleep_state_o |-> $stable(dq_oe_n_o);
    endproperty
    a_hold: assert property (p_hold) else $error("held edge changed drive");
endmodule
bind ftsp_core ftsp_core_props u_props (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_hold_i(clk_hold_i),
    .burst_step_i(burst_step_i), .store_sel_n_i(store_sel_n_i),
    .byte_lane_strobes_n_i(byte_lane_strobes_n_i), .chip_sel_first_n_i(chip_sel_first_n_i),
    .chip_sel_second_i(chip_sel_second_i), .chip_sel_third_n_i(chip_sel_third_n_i),
    .out_enable_n_i(out_enable_n_i), .sleep_request_i(sleep_request_i),
    .dq_oe_n_o(dq_oe_n_o), .sleep_state_o(sleep_state_o)
);
`default_nettype wire

// File: ftsp_ctrl_model.sv
// Memory controller model driving bus cycles into the RAM port.
// Assumes cycles are issued back to back, one per clock.
`timescale 1ns/1ps
`default_nettype none
module ftsp_ctrl_model
    import ftsp_pkg::*;
(
    input wire logic core_clk_i,
    output logic step_o,
    output logic st_n_o,
    output logic [LANES-1:0] be_n_o,
    output logic [2:0] cs_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] dq_o
);
    logic wr_q = 1'b0;
    logic [DATA_W-1:0] d_q = '0;
    initial begin
        {step_o, st_n_o, be_n_o, cs_o, addr_o, dq_o} = {2'h1, 4'hF, 3'h6, 10'h000, 36'h0};
    end
    task automatic cyc(input logic s, input logic w, input logic [3:0] b, input logic [2:0] c,
                       input logic [9:0] a, input logic [35:0] d, input logic dw);
        @(negedge core_clk_i);
        {step_o, st_n_o, be_n_o, cs_o, addr_o} <= {s, w, b, c, a};
        // Released data lines toggle rather than hold
        dq_o <= wr_q ? d_q : ~dq_o;
        wr_q <= dw;
        d_q <= d;
    endtask
endmodule
`default_nettype wire

// File: ftsp_core_tb_top.sv
// Self-checking bench for the RAM port.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module ftsp_core_tb_top
    import ftsp_pkg::*;
;
    localparam logic [DATA_W-1:0] FULL = 36'hF0F0F0F0F;
    localparam logic [DATA_W-1:0] PART = 36'h5A5A5A5A5;
    logic clk = 1'b0, rst = 1'b1, hold = 1'b0, oe_n = 1'b0, slp = 1'b0;
    logic linear_order_n = 1'b0;
    logic step, st_n, oen, rdy, slps;
    logic [2:0] cs;
    logic [LANES-1:0] be_n, b;
    logic [ADDR_W-1:0] addr, a;
    logic [DATA_W-1:0] dqi, q;
    int fail_count = 0, cmp_count = 0;
    logic [13:0] rows [5] = '{14'h0010, 14'h002E, 14'h0037, 14'h004F, 14'h3FF5};
    ftsp_ctrl_model m (.core_clk_i(clk), .step_o(step), .st_n_o(st_n), .be_n_o(be_n),
        .cs_o(cs), .addr_o(addr), .dq_o(dqi));
    ftsp_core DUT (.core_clk_i(clk), .sys_rst_i(rst), .clk_hold_i(hold), .burst_step_i(step),
        .store_sel_n_i(st_n), .byte_lane_strobes_n_i(be_n), .chip_sel_first_n_i(cs[2]),
        .chip_sel_second_i(cs[1]), .chip_sel_third_n_i(cs[0]), .out_enable_n_i(oe_n),
        .sleep_request_i(slp), .linear_order_n_i(linear_order_n), .burst_addr_i(addr), .dq_i(dqi),
        .dq_o(q), .dq_oe_n_o(oen), .wr_buf_ready_o(rdy), .sleep_state_o(slps));
    initial begin
        forever #2 clk = ~clk;
    end
    function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] s);
        for (int g = 0; g < 4; g++) if (!s[g]) o[g*9+:9] = n[g*9+:9];
        return o;
    endfunction
    task automatic ld(input logic w, input logic [3:0] s, input logic [9:0] ad, input logic [35:0] d);
        m.cyc(1'b0, w, s, 3'h2, ad, d, !w);
    endtask
    task automatic nop;
        m.cyc(1'b0, 1'b1, 4'hF, 3'h6, 10'h000, 36'h0, 1'b0);
    endtask
    task automatic rdchk(input logic [35:0] e);
        @(posedge clk);
        #1 `CHK(oen, 1'b0)
        `CHK(q, e)
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (10) @(negedge clk);
        `CHK(oen, 1'b1)
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            a = rows[i][13:4];
            b = rows[i][3:0];
            ld(1'b0, 4'h0, a, FULL);
            ld(1'b0, b, a, PART);
            nop;
            ld(1'b1, 4'hF, a, 36'h0);
            rdchk(mrg(FULL, PART, b));
        end
        `CHK(rdy, 1'b1)
        $display("test lanes done");
        for (int k = 0; k < 4; k++) m.cyc(k != 0, 1'b0, 4'h0, 3'h2, 10'h012, 36'h100 + k, 1'b1);
        nop;
        for (int k = 0; k < 5; k++) begin
            m.cyc(k != 0, 1'b1, 4'hF, 3'h2, 10'h013, 36'h0, 1'b0);
            rdchk(36'h100 + ((k + 1) % 4));
        end
        $display("test burst done");
        ld(1'b1, 4'hF, 10'h013, 36'h0);
        rdchk(36'h101);
        ld(1'b1, 4'hF, 10'h010, 36'h0);
        hold = 1'b1;
        rdchk(36'h101);
        @(negedge clk) hold = 1'b0;
        rdchk(36'h102);
        #1 oe_n = 1'b1;
        #0.5 `CHK(oen, 1'b1)
        oe_n = 1'b0;
        $display("test hold done");
        for (int k = 0; k < 4; k++) begin
            m.cyc(k == 3, 1'b1, 4'hF, (k == 0) ? 3'h6 : (k == 1) ? 3'h0 : 3'h3, 10'h010, 36'h0, 1'b0);
            @(posedge clk);
            #1 `CHK(oen, 1'b1)
        end
        $display("test deselect done");
        nop;
        slp = 1'b1;
        @(posedge clk);
        #1 `CHK(slps, 1'b0)
        nop;
        @(posedge clk);
        #1 `CHK(slps, 1'b1)
        `CHK(oen, 1'b1)
        nop;
        nop;
        slp = 1'b0;
        nop;
        nop;
        ld(1'b1, 4'hF, 10'h010, 36'h0);
        rdchk(36'h102);
        $display("test sleep done");
        nop;
        rst = 1'b1;
        linear_order_n = 1'b1;
        m.cyc(1'b1, 1'b1, 4'hF, 3'h2, 10'h000, 36'h0, 1'b0);
        @(negedge clk);
        `CHK(oen, 1'b1)
        rst = 1'b0;
        @(posedge clk);
        #1 `CHK(oen, 1'b1)
        for (int k = 0; k < 4; k++) begin
            m.cyc(k != 0, 1'b1, 4'hF, 3'h2, 10'h013, 36'h0, 1'b0);
            rdchk(36'h100 + (((3 ^ k) + 2) % 4));
        end
        $display("test reset done");
        end_sim;
    end
endmodule
`default_nettype wire
